//--- common/plmc_regs.vh
// Register offsets, field positions and reset values of the logic block
`ifndef PLMC_REGS_VH
`define PLMC_REGS_VH

// Offsets (word index on the register port)
`define PLMC_MC_CFG_BASE   5'h00
`define PLMC_CTRL_ADDR     5'h10
`define PLMC_STATUS_ADDR   5'h11
`define PLMC_STATE_ADDR    5'h12
`define PLMC_PINS_ADDR     5'h13

// Macrocell configuration fields
`define PLMC_MODE_LSB      0
`define PLMC_MODE_MSB      1
`define PLMC_INCAP_BIT     2
`define PLMC_CLKSEL_LSB    3
`define PLMC_CLKSEL_MSB    4
`define PLMC_LOWPWR_BIT    5
`define PLMC_OEMODE_LSB    6
`define PLMC_OEMODE_MSB    7

// Storage modes
`define PLMC_MODE_COMB     2'h0
`define PLMC_MODE_DREG     2'h1
`define PLMC_MODE_TREG     2'h2
`define PLMC_MODE_LATCH    2'h3

// Three-state driver modes
`define PLMC_OE_ALWAYS     2'h0
`define PLMC_OE_NEVER      2'h1
`define PLMC_OE_TERM0      2'h2
`define PLMC_OE_TERM1      2'h3

// Control register fields
`define PLMC_CTRL_ISP_BIT  0
`define PLMC_CTRL_SEC_BIT  1
`define PLMC_CTRL_ERASE_BIT 2

// Reset values
`define PLMC_MC_CFG_RESET  8'h41
`define PLMC_CTRL_RESET    8'h00

`endif

//--- rtl/plmc_logic_block.v
// One logic block: macrocells, I/O cells, clock pins and configuration
//
// Notes on behaviour
// RQ1 - Buried macrocell feeds back only, never pins
// RQ2 - Buried macrocell can capture input, flop or latch
// RQ3 - Input capture ignores product-term logic
// RQ4 - Flip-flops change only on selected clock rise
// RQ5 - Latch holds while gate high, passes low
// RQ6 - Clock picked from two or four pins
// RQ7 - Clock pins also readable as data inputs
// RQ8 - One clear and one set term per block
// RQ9 - Clear beats set; latch init while transparent illegal
// RQ10 - Driver always on, always off, or term-enabled
// RQ11 - Two enable terms shared by all I/O cells
// RQ12 - All outputs float during in-system programming
// RQ13 - Programming via compliant boundary-scan port; here ISP is set through the register port
// RQ14 - Released pins keep their last driven level
// RQ15 - Each path may run slow low-power mode
// RQ16 - Power-up clears every flip-flop low
// RQ17 - Outside keeps clocks idle through power-up
// RQ18 - Security bit blocks readback, programming; erase clears
// RQ19 - Register can be D or toggle type
// RQ20 - Latch option only where buried cells exist
// RQ21 - Cell count, clocks, buried cells are parameters
// RQ22 - Storage has clear and set, clear first
`timescale 1ns/1ps
`include "plmc_regs.vh"

module plmc_logic_block #(
   parameter NUM_MC     = 8,   // Macrocells in the block (see RQ21)
   parameter NUM_CLK    = 4,   // Dedicated clock pins, 2 or 4 (see RQ6)
   parameter HAS_BURIED = 1    // Odd macrocells buried when set (see RQ21)
) (
   // Clock and reset
   input  wire              sys_clk,
   input  wire              rst,
   // Register port
   input  wire [4:0]        regAddr,
   input  wire [7:0]        regWrData,
   input  wire              regWr,
   input  wire              regRd,
   output reg  [7:0]        regRdData,
   // Dedicated clock pins, also used as data
   input  wire [NUM_CLK-1:0] clkPin,
   output wire [NUM_CLK-1:0] clkPinLevel,
   // Product-term results from the array
   input  wire [NUM_MC-1:0] termSum,
   input  wire              blockAsyncClearTerm,
   input  wire              blockAsyncSetTerm,
   input  wire              oeTerm0,
   input  wire              oeTerm1,
   // Switch-matrix feedback
   output wire [NUM_MC-1:0] feedback,
   // Pins of the I/O cells (two-way)
   input  wire [NUM_MC-1:0] padIn,
   input  wire [NUM_MC-1:0] padExtDriven,
   output wire [NUM_MC-1:0] padOut,
   output wire [NUM_MC-1:0] padOe,
   output wire [NUM_MC-1:0] padLevel,
   // Status
   output wire              securityOn,
   output wire              ispActive,
   output reg               initIllegal
);

   // Pin synchronisers; stage one is read only by stage two
   reg [NUM_CLK-1:0] clkMeta;     // First stage, clock pins
   reg [NUM_CLK-1:0] clkSync;     // Second stage, clock pins
   reg [NUM_CLK-1:0] clkPrev;     // Edge detect history
   reg [NUM_MC-1:0]  padMeta;     // First stage, pad data
   reg [NUM_MC-1:0]  padSync;     // Second stage, pad data
   reg [NUM_MC-1:0]  drvMeta;     // First stage, outside drive flag
   reg [NUM_MC-1:0]  drvSync;     // Second stage, outside drive flag

   // Configuration and state
   reg [7:0]         mcCfg [0:NUM_MC-1]; // Per-macrocell setup
   reg               ispOn;       // Programming in progress
   reg               secBit;      // Security fuse
   reg [NUM_MC-1:0]  mcQ;         // Storage element of each macrocell
   reg [NUM_MC-1:0]  mcQSlow;     // Extra stage for low-power paths
   reg [NUM_MC-1:0]  padHold;     // Weak hold level per pin
   reg [NUM_MC-1:0]  padDrv;      // Registered pad data
   reg [NUM_MC-1:0]  padEn;       // Registered pad enable
   reg [NUM_MC-1:0]  next_mcQ;    // Storage next value
   reg [NUM_MC-1:0]  next_padEn;  // Enable next value
   reg               next_bad;    // Illegal latch init seen
   integer           i;           // Loop index, next-value logic
   integer           j;           // Loop index, bus hold
   integer           k;           // Loop index, configuration

   // Decoded port accesses
   wire cfgHit  = (regAddr < NUM_MC);
   wire ctrlWr  = regWr && (regAddr == `PLMC_CTRL_ADDR);
   wire eraseWr = ctrlWr && regWrData[`PLMC_CTRL_ERASE_BIT];

   assign clkPinLevel = clkSync;   // Clock pins double as inputs (see RQ7)
   assign securityOn  = secBit;
   assign ispActive   = ispOn;

   // True where a cell is buried: odd index, only if the variant has them
   function isBuried;
      input integer idx;
      begin
         isBuried = (HAS_BURIED != 0) && (idx % 2 == 1);
      end
   endfunction

   // Next stored value for one macrocell
   function cellNext;
      input [1:0] mode;
      input       dIn;
      input       q;
      input       rise;
      input       gate;
      begin
         case (mode)
            `PLMC_MODE_DREG: cellNext = rise ? dIn : q;      // see RQ4
            `PLMC_MODE_TREG: cellNext = rise ? (q ^ dIn) : q; // see RQ19
            `PLMC_MODE_LATCH: cellNext = gate ? q : dIn;     // see RQ5
            default: cellNext = dIn;   // Combinational path
         endcase
      end
   endfunction

   // Two-stage synchronisers and clock edge history
   always @(posedge sys_clk) begin
      if (rst) begin
         clkMeta <= {NUM_CLK{1'b0}};
         clkSync <= {NUM_CLK{1'b0}};
         clkPrev <= {NUM_CLK{1'b0}};
         padMeta <= {NUM_MC{1'b0}};
         padSync <= {NUM_MC{1'b0}};
         drvMeta <= {NUM_MC{1'b0}};
         drvSync <= {NUM_MC{1'b0}};
      end else begin
         clkMeta <= clkPin;
         clkSync <= clkMeta;
         clkPrev <= clkSync;
         padMeta <= padIn;
         padSync <= padMeta;
         drvMeta <= padExtDriven;
         drvSync <= drvMeta;
      end
   end

   // Storage next values; clear term beats set term
   always @* begin
      next_mcQ   = mcQ;
      next_padEn = {NUM_MC{1'b0}};
      next_bad   = 1'b0;
      for (i = 0; i < NUM_MC; i = i + 1) begin
         // Latch mode exists only with buried cells (see RQ20)
         if (isBuried(i) &&
             mcCfg[i][`PLMC_INCAP_BIT]) begin
            // Input capture: pin data, array ignored (see RQ2, RQ3)
            next_mcQ[i] = cellNext(
               (mcCfg[i][`PLMC_MODE_MSB:`PLMC_MODE_LSB] ==
                `PLMC_MODE_LATCH && HAS_BURIED != 0) ?
                  `PLMC_MODE_LATCH : `PLMC_MODE_DREG,
               padSync[i], mcQ[i],
               clkSync[mcCfg[i][`PLMC_CLKSEL_MSB:`PLMC_CLKSEL_LSB]
                       % NUM_CLK] &
               ~clkPrev[mcCfg[i][`PLMC_CLKSEL_MSB:`PLMC_CLKSEL_LSB]
                        % NUM_CLK],
               clkSync[mcCfg[i][`PLMC_CLKSEL_MSB:`PLMC_CLKSEL_LSB]
                       % NUM_CLK]);
         end else begin
            // Clock selected per cell (see RQ6)
            next_mcQ[i] = cellNext(
               (mcCfg[i][`PLMC_MODE_MSB:`PLMC_MODE_LSB] ==
                `PLMC_MODE_LATCH && HAS_BURIED == 0) ?
                  `PLMC_MODE_DREG :
                  mcCfg[i][`PLMC_MODE_MSB:`PLMC_MODE_LSB],
               termSum[i], mcQ[i],
               clkSync[mcCfg[i][`PLMC_CLKSEL_MSB:`PLMC_CLKSEL_LSB]
                       % NUM_CLK] &
               ~clkPrev[mcCfg[i][`PLMC_CLKSEL_MSB:`PLMC_CLKSEL_LSB]
                        % NUM_CLK],
               clkSync[mcCfg[i][`PLMC_CLKSEL_MSB:`PLMC_CLKSEL_LSB]
                       % NUM_CLK]);
         end
         // Shared block terms act on every cell not in combinational mode (see RQ8, RQ22)
         if (mcCfg[i][`PLMC_MODE_MSB:`PLMC_MODE_LSB] !=
             `PLMC_MODE_COMB) begin
            if (blockAsyncClearTerm)
               next_mcQ[i] = 1'b0;                         // see RQ9
            else if (blockAsyncSetTerm)
               next_mcQ[i] = 1'b1;                         // see RQ9
            // Init on a transparent latch is undefined; flag it
            if ((blockAsyncClearTerm || blockAsyncSetTerm) &&
                HAS_BURIED != 0 &&
                mcCfg[i][`PLMC_MODE_MSB:`PLMC_MODE_LSB] ==
                `PLMC_MODE_LATCH &&
                !clkSync[mcCfg[i][`PLMC_CLKSEL_MSB:`PLMC_CLKSEL_LSB]
                         % NUM_CLK])
               next_bad = 1'b1;                            // see RQ9
         end
         // Driver enable from shared terms (see RQ10, RQ11)
         case (mcCfg[i][`PLMC_OEMODE_MSB:`PLMC_OEMODE_LSB])
            `PLMC_OE_ALWAYS: next_padEn[i] = 1'b1;
            `PLMC_OE_NEVER:  next_padEn[i] = 1'b0;
            `PLMC_OE_TERM0:  next_padEn[i] = oeTerm0;
            default:         next_padEn[i] = oeTerm1;
         endcase
         // Buried cells never reach a pin (see RQ1)
         if (isBuried(i) || ispOn)
            next_padEn[i] = 1'b0;                          // see RQ12
      end
   end

   // Storage, low-power stage and pad drivers
   always @(posedge sys_clk) begin
      if (rst) begin
         mcQ         <= {NUM_MC{1'b0}};                    // see RQ16
         mcQSlow     <= {NUM_MC{1'b0}};
         padDrv      <= {NUM_MC{1'b0}};
         padEn       <= {NUM_MC{1'b0}};
         initIllegal <= 1'b0;
      end else begin
         mcQ         <= next_mcQ;
         mcQSlow     <= mcQ;
         padDrv      <= feedback;
         padEn       <= next_padEn;
         initIllegal <= next_bad;
      end
   end

   // Low-power paths see one extra cycle of delay (see RQ15)
   genvar g;
   generate
      for (g = 0; g < NUM_MC; g = g + 1) begin : gPath
         assign feedback[g] = mcCfg[g][`PLMC_LOWPWR_BIT] ?
                              mcQSlow[g] : mcQ[g];
      end
   endgenerate

   assign padOut = padDrv & padEn;
   assign padOe  = padEn;

   // Bus hold: remember the last level anyone drove (see RQ14)
   always @(posedge sys_clk) begin
      if (rst) begin
         padHold <= {NUM_MC{1'b0}};
      end else begin
         for (j = 0; j < NUM_MC; j = j + 1) begin
            if (padEn[j])
               padHold[j] <= padDrv[j];
            else if (drvSync[j])
               padHold[j] <= padSync[j];
         end
      end
   end
   assign padLevel = padHold;

   // Configuration writes; blocked while secure (see RQ18)
   always @(posedge sys_clk) begin
      if (rst) begin
         ispOn  <= 1'b0;
         secBit <= 1'b0;
         for (k = 0; k < NUM_MC; k = k + 1)
            mcCfg[k] <= `PLMC_MC_CFG_RESET;
      end else if (eraseWr) begin
         // Full erase and reset are the only ways to drop security
         secBit <= 1'b0;                                   // see RQ18
         ispOn  <= regWrData[`PLMC_CTRL_ISP_BIT];
         for (k = 0; k < NUM_MC; k = k + 1)
            mcCfg[k] <= `PLMC_MC_CFG_RESET;
      end else begin
         if (ctrlWr) begin
            // Programming session flag from the register port control word
            ispOn <= regWrData[`PLMC_CTRL_ISP_BIT];        // see RQ13
            if (regWrData[`PLMC_CTRL_SEC_BIT])
               secBit <= 1'b1;
         end
         if (regWr && cfgHit && !secBit)
            mcCfg[regAddr[4:0] % NUM_MC] <= regWrData;     // see RQ18
      end
   end

   // Read data, one cycle after the strobe
   always @(posedge sys_clk) begin
      if (rst) begin
         regRdData <= 8'h00;
      end else if (regRd) begin
         if (cfgHit)
            // Secured pattern reads back as zero (see RQ18)
            regRdData <= secBit ? 8'h00 : mcCfg[regAddr % NUM_MC];
         else if (regAddr == `PLMC_CTRL_ADDR)
            regRdData <= {7'h00, ispOn};
         else if (regAddr == `PLMC_STATUS_ADDR)
            regRdData <= {5'h00, initIllegal, secBit, ispOn};
         else if (regAddr == `PLMC_STATE_ADDR)
            regRdData <= mcQ[7:0];
         else if (regAddr == `PLMC_PINS_ADDR)
            regRdData <= padHold[7:0];
         else
            regRdData <= 8'h00;   // Unmapped reads as zero
      end else begin
         regRdData <= 8'h00;
      end
   end

endmodule

//--- tb/plmc_board.sv
// Board model: clock pins and pad wires around the logic block
`timescale 1ns/1ps
module plmc_board #(
   parameter NUM_MC  = 8,
   parameter NUM_CLK = 4
) (
   // Clock
   input  wire               sys_clk,
   // Pad side of the block
   input  wire [NUM_MC-1:0]  padOut,
   input  wire [NUM_MC-1:0]  padOe,
   input  wire [NUM_MC-1:0]  padLevel,
   output wire [NUM_MC-1:0]  padIn,
   output wire [NUM_MC-1:0]  padExtDriven,
   // Dedicated clock pins
   output reg  [NUM_CLK-1:0] clkPin
);
   reg  [NUM_MC-1:0]         extOn;  // Board drives the pad
   reg  [NUM_MC-1:0]         extVal; // Level the board drives
   // A pad shows the board's drive, else the block's, else the held level
   assign padExtDriven = extOn;
   assign padIn = (extOn & extVal) |
                  (~extOn & ((padOe & padOut) | (~padOe & padLevel)));
   // Pins idle low through power-up and reset; pads undriven
   initial begin
      clkPin = {NUM_CLK{1'h0}};
      extOn  = {NUM_MC{1'h0}};
      extVal = {NUM_MC{1'h0}};
   end
   // One pulse on pin k, long enough to pass the two-flop sync
   task pulse(input integer k);
      begin
         @(posedge sys_clk) clkPin[k] <= 1'h1;
         repeat (4) @(posedge sys_clk);
         clkPin[k] <= 1'h0;
         repeat (4) @(posedge sys_clk);
      end
   endtask
   // Hold clock pin k at level v from the next edge
   task setPin(input integer k, input v);
      @(posedge sys_clk) clkPin[k] <= v;
   endtask
   // Drive pad k to v, or release it when on is low
   task drive(input integer k, input on, input v);
      begin
         @(posedge sys_clk) extOn[k] <= on;
         extVal[k] <= v;
      end
   endtask
endmodule

//--- tb/plmc_logic_block_properties.sv
// Port-level checks of the logic block
`timescale 1ns/1ps
`include "plmc_regs.vh"
module plmc_logic_block_properties #(
   parameter NUM_MC     = 8,
   parameter NUM_CLK    = 4,
   parameter HAS_BURIED = 1
) (
   // Clock and reset
   input wire               sys_clk,
   input wire               rst,
   // Register port
   input wire [4:0]         regAddr,
   input wire [7:0]         regWrData,
   input wire               regWr,
   input wire               regRd,
   input wire [7:0]         regRdData,
   // Pins and status
   input wire [NUM_CLK-1:0] clkPin,
   input wire [NUM_CLK-1:0] clkPinLevel,
   input wire [NUM_MC-1:0]  feedback,
   input wire [NUM_MC-1:0]  padOe,
   input wire [NUM_MC-1:0]  padOut,
   input wire               securityOn,
   input wire               ispActive
);
   // Odd cells are buried when the option is on
   localparam [NUM_MC-1:0] BURIED =
      (HAS_BURIED != 0) ? {NUM_MC/2{2'h2}} : {NUM_MC{1'h0}};
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // A write to the control register
   sequence s_ctrl_wr;
      regWr && regAddr == `PLMC_CTRL_ADDR;
   endsequence
   property p_buried_quiet;
      ((padOe | padOut) & BURIED) == '0;
   endproperty
   a_buried_quiet: assert property (p_buried_quiet)
      else $error("buried cell drives a pad");
   property p_isp_float;
      ispActive |=> padOe == '0;
   endproperty
   a_isp_float: assert property (p_isp_float)
      else $error("pad driven while programming");
   property p_isp_ctrl;
      s_ctrl_wr ##0 !securityOn |=> ispActive == $past(regWrData[0]);
   endproperty
   a_isp_ctrl: assert property (p_isp_ctrl)
      else $error("programming flag not taken");
   property p_sec_set;
      s_ctrl_wr ##0 (regWrData[1] && !regWrData[2]) |=> securityOn;
   endproperty
   a_sec_set: assert property (p_sec_set)
      else $error("security not set");
   // Only a write to the control word may drop security
   property p_sec_keep;
      securityOn && !(regWr && regAddr == `PLMC_CTRL_ADDR) |=> securityOn;
   endproperty
   a_sec_keep: assert property (p_sec_keep)
      else $error("security dropped");
   property p_sec_hide;
      regRd && regAddr < NUM_MC && securityOn |=> regRdData == 8'h00;
   endproperty
   a_sec_hide: assert property (p_sec_hide)
      else $error("config readable while secure");
   property p_reset_low;
      disable iff (1'h0) rst |=> feedback == '0 && padOe == '0;
   endproperty
   a_reset_low: assert property (p_reset_low)
      else $error("state not cleared by reset");
   property p_clk_data;
      !$past(rst) && !$past(rst, 2) |-> clkPinLevel == $past(clkPin, 2);
   endproperty
   a_clk_data: assert property (p_clk_data)
      else $error("clock pin level not two cycles behind");
endmodule
bind plmc_logic_block plmc_logic_block_properties #(
   .NUM_MC(NUM_MC), .NUM_CLK(NUM_CLK), .HAS_BURIED(HAS_BURIED)) chk (
   .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
   .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
   .regRdData(regRdData), .clkPin(clkPin), .clkPinLevel(clkPinLevel),
   .feedback(feedback), .padOe(padOe), .padOut(padOut),
   .securityOn(securityOn), .ispActive(ispActive));

//--- tb/plmc_logic_block_test.sv
// Self-checking bench for the logic block with its board model
`timescale 1ns/1ps
`include "plmc_regs.vh"
module plmc_logic_block_test;
   // Rows: mode [3:2], data in [1], expected state [0]
   localparam [19:0] ROWS = 20'h8ab47;
   reg        sys_clk, rst, regWr, regRd, clrTerm, setTerm;
   reg  [4:0] regAddr;
   reg  [7:0] regWrData, termSum;
   reg  [1:0] oeTerm;
   wire [7:0] regRdData, feedback, padOut, padOe, padLevel, padIn, padExt;
   wire [3:0] clkPin;
   wire       securityOn, initIllegal;
   integer    miscompares, samples_checked, i;
   plmc_logic_block dut (
      .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .clkPin(clkPin), .clkPinLevel(),
      .termSum(termSum), .blockAsyncClearTerm(clrTerm),
      .blockAsyncSetTerm(setTerm), .oeTerm0(oeTerm[0]),
      .oeTerm1(oeTerm[1]), .feedback(feedback), .padIn(padIn),
      .padExtDriven(padExt), .padOut(padOut), .padOe(padOe),
      .padLevel(padLevel), .securityOn(securityOn), .ispActive(),
      .initIllegal(initIllegal));
   plmc_board board (
      .sys_clk(sys_clk), .padOut(padOut), .padOe(padOe),
      .padLevel(padLevel), .padIn(padIn), .padExtDriven(padExt),
      .clkPin(clkPin));
   // 40 MHz system clock
   initial begin
      sys_clk = 1'h0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // Compare a settled 8-bit result
   task chk(input [63:0] n, input [7:0] e, input [7:0] s);
      begin
         samples_checked = samples_checked + 1;
         if (s !== e) begin
            miscompares = miscompares + 1;
            $display("ERROR %0s expected %h seen %h", n, e, s);
         end
      end
   endtask
   task note(input [63:0] n);
      $display("test %0s done", n);
   endtask
   // Wait n edges, then sample away from the edge
   task wt(input integer n);
      begin
         repeat (n) @(posedge sys_clk);
         @(negedge sys_clk);
      end
   endtask
   // One-cycle register write
   task wr(input [4:0] a, input [7:0] d);
      begin
         @(posedge sys_clk);
         regAddr <= a;
         regWrData <= d;
         regWr <= 1'h1;
         @(posedge sys_clk);
         regWr <= 1'h0;
      end
   endtask
   // Read: data stand only in the cycle after the strobe
   task rd(input [4:0] a, input [7:0] e);
      begin
         @(posedge sys_clk);
         regAddr <= a;
         regRd <= 1'h1;
         @(posedge sys_clk);
         regRd <= 1'h0;
         @(negedge sys_clk);
         chk("rdata", e, regRdData);
      end
   endtask
   task close_out;
      begin
         $display("checks %0d mismatches %0d", samples_checked, miscompares);
         if (miscompares == 0 && samples_checked > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   // Whole run needs well under a thousand cycles
   initial begin
      #(25 * 4000);
      miscompares = miscompares + 1;
      close_out;
   end
   initial begin
      miscompares = 0;
      samples_checked = 0;
      rst = 1'h1;
      regAddr = 5'h00;
      regWrData = 8'h00;
      regWr = 1'h0;
      regRd = 1'h0;
      termSum = 8'h00;
      clrTerm = 1'h0;
      setTerm = 1'h0;
      oeTerm = 2'h0;
      repeat (2) @(posedge sys_clk);
      rst <= 1'h0;
      rd(`PLMC_MC_CFG_BASE, `PLMC_MC_CFG_RESET);
      rd(`PLMC_CTRL_ADDR, `PLMC_CTRL_RESET);
      chk("fb", 8'h00, feedback);
      note("reset");
      // D and toggle rows on clock pin 0
      for (i = 0; i < 5; i = i + 1) begin
         wr(`PLMC_MC_CFG_BASE, {6'h00, ROWS[4*i+2 +: 2]});
         termSum <= {8{ROWS[4*i+1]}};
         board.pulse(0);
         wt(0);
         chk("fb0", {7'h00, ROWS[4*i]}, {7'h00, feedback[0]});
      end
      // Data moves with the clock pin quiet: state must hold
      @(posedge sys_clk) termSum <= 8'hff;
      wt(8);
      chk("hold", 8'h00, feedback);
      note("storage");
      // Clear and set together, then set alone, on every cell
      @(posedge sys_clk) setTerm <= 1'h1;
      clrTerm <= 1'h1;
      wt(3);
      chk("clr", 8'h00, feedback);
      @(posedge sys_clk) clrTerm <= 1'h0;
      wt(3);
      chk("set", 8'hff, feedback);
      @(posedge sys_clk) setTerm <= 1'h0;
      note("init");
      // Driver always on for cell 0, never for the rest
      wr(`PLMC_MC_CFG_BASE, 8'h01);
      wt(3);
      chk("oe", 8'h01, padOe);
      chk("pad", 8'h01, padOut);
      // Cell 0 on the second shared term, cell 2 on the first
      wr(`PLMC_MC_CFG_BASE, 8'hc1);
      wr(`PLMC_MC_CFG_BASE + 5'h02, 8'h81);
      @(posedge sys_clk) oeTerm <= 2'h2;
      wt(3);
      chk("oet1", 8'h01, padOe);
      @(posedge sys_clk) oeTerm <= 2'h1;
      wt(3);
      chk("oet0", 8'h04, padOe);
      wr(`PLMC_CTRL_ADDR, 8'h01);
      wt(2);
      chk("isp", 8'h00, padOe);
      note("pads");
      // Security hides config; erase clears it; unmapped reads zero
      wr(`PLMC_CTRL_ADDR, 8'h02);
      rd(`PLMC_MC_CFG_BASE, 8'h00);
      // A pattern write while secure must not land
      wr(`PLMC_MC_CFG_BASE, 8'h01);
      wt(2);
      chk("lock", 8'h04, padOe);
      chk("sec", 8'h01, {7'h00, securityOn});
      wr(`PLMC_CTRL_ADDR, 8'h04);
      rd(`PLMC_STATUS_ADDR, 8'h00);
      rd(5'h1f, 8'h00);
      note("secure");
      // Latch: transparent while the gate pin is low, holds while high
      wr(`PLMC_MC_CFG_BASE, 8'h43);
      termSum <= 8'h00;
      wt(2);
      chk("lat", 8'hfe, feedback);
      board.setPin(0, 1'h1);
      wt(3);
      @(posedge sys_clk) termSum <= 8'hff;
      wt(2);
      chk("lathold", 8'h00, feedback);
      // Set with the gate high is legal; clear with it low is flagged
      @(posedge sys_clk) setTerm <= 1'h1;
      @(posedge sys_clk) setTerm <= 1'h0;
      wt(0);
      chk("legal", 8'h00, {7'h00, initIllegal});
      chk("latset", 8'hff, feedback);
      board.setPin(0, 1'h0);
      wt(3);
      @(posedge sys_clk) clrTerm <= 1'h1;
      @(posedge sys_clk) clrTerm <= 1'h0;
      wt(0);
      chk("illegal", 8'h01, {7'h00, initIllegal});
      chk("latclr", 8'h00, feedback);
      note("latch");
      // Buried cell 1 takes its pad on clock pin 0, array ignored
      wr(`PLMC_MC_CFG_BASE + 5'h01, 8'h45);
      termSum <= 8'h00;
      board.drive(1, 1'h1, 1'h1);
      board.pulse(0);
      wt(0);
      chk("capture", 8'h02, feedback);
      // Released pad keeps the level last driven on it
      board.drive(1, 1'h0, 1'h0);
      wt(4);
      chk("bushold", 8'h01, {7'h00, padLevel[1]});
      note("capture");
      // Low-power path on clock pin 1: feedback lags the state a cycle
      wr(`PLMC_MC_CFG_BASE, 8'h69);
      termSum <= 8'hff;
      board.setPin(1, 1'h1);
      wt(3);
      chk("slow", 8'h00, {7'h00, feedback[0]});
      wt(1);
      chk("clk1", 8'h01, {7'h00, feedback[0]});
      note("lowpower");
      close_out;
   end
endmodule
